// >>> pkg/sssp_pkg.sv
// Shared constants and types of the supervisor serial slave port
package sssp_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ = 10000;
    localparam real BOOT_MS = 2.5;
    localparam int BOOT_CYC = int'(BOOT_MS * CLK_KHZ);
    localparam int EE_WR_CYC = 1000;

    // ****************************************
    // Bus address and command codes
    // ****************************************
    localparam logic [3:0] ADDR_FIXED = 4'hA;
    localparam logic [7:0] CMD_BLK_WR = 8'hC0;
    localparam logic [7:0] CMD_BLK_RD = 8'hC1;
    localparam logic [7:0] CMD_REBOOT = 8'hC4;
    localparam logic [7:0] BLK_RD_COUNT = 8'h10;

    // ****************************************
    // Register map
    // ****************************************
    localparam int CFG_N = 24;
    localparam logic [7:0] CFG_LAST = 8'h17;
    localparam logic [7:0] CONV_BASE = 8'h18;
    localparam logic [7:0] AUX_INPUT_CONVERSION_LOW = 8'h25;
    localparam logic [7:0] SUPPLY_CONVERSION_HIGH = 8'h26;
    localparam logic [7:0] SUPPLY_CONVERSION_LOW = 8'h27;
    localparam logic [7:0] PRIMARY_DETECTOR_FAULT_FLAGS = 8'h28;
    localparam logic [7:0] SECONDARY_DETECTOR_FAULT_FLAGS = 8'h29;
    localparam logic [7:0] OUTPUT_EVENT_FAULT_FLAGS = 8'h2A;
    localparam logic [7:0] REG_LAST = 8'h2F;
    localparam logic [7:0] EE_BASE = 8'h80;
    localparam logic [7:0] EE_LAST = 8'h97;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************
    // Factory default
    // ****************************************
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_DEF_SET = 8'h01;
    localparam logic [7:0] CFG_DEF_LO = 8'h11;
    localparam logic [7:0] CFG_DEF_HI = 8'h15;

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX} sssp_state_t;
    typedef enum logic [1:0] {BY_ADDR, BY_CMD, BY_DATA} sssp_kind_t;

endpackage

// >>> logic/sssp_core.sv
// Two-wire slave port with register bank, config image and software reboot
//
// Summary of operation
// - Factory default: all config zero except bit 0 of 11h..15h.
// - Reboot code as send byte reloads volatile config from stored image.
// - After reboot, full power-up delay passes before normal operation resumes.
// - Slave only; clock is never driven; works up to 400 kHz.
// - Every byte is eight bits followed by one acknowledge bit.
// - START is data falling, STOP data rising, while clock high.
// - STOP recognised anywhere; master separates START and STOP by a pulse.
// - Writes accepted with or without repeated START; block reads need one.
// - Accepted address or data byte acknowledged low for whole ninth clock.
// - When transmitting, release data in ninth clock and sample master ack.
// - Command byte refused during reboot, EEPROM write, or illegal address.
// - Address bits 7..4 fixed, bit 3 zero, bit 2 strap, bit 1 ignored.
// - Address bit 0 is direction: zero write, one read.
// - Send byte loads the address pointer used by the next transfer.
// - Block-write code is acknowledged and further block bytes expected.
// - Block-read code prepares a block read after repeated START.
// - STOP instead of the command byte leaves the pointer unchanged.
// - Send byte: START, address write, ack, byte, ack, STOP.
// - Read-only conversion halves and three fault-flag registers.
// - Unused register addresses read as zero.
module sssp_core
    import sssp_pkg::*;
#(
    parameter int P_BOOT_CYC = BOOT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_strap,
    input wire logic [7:0][9:0] i_conv_result,
    input wire logic [7:0] i_fault_primary,
    input wire logic [7:0] i_fault_secondary,
    input wire logic [7:0] i_fault_output,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    output logic o_reboot_busy,
    output logic o_ee_busy
);

    // ****************************************
    // Link domain: data sampled on clock rise
    // ****************************************
    logic rise_tog;
    logic rise_bit;

    // Bit held until the next rise, well after the toggle crosses over
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            rise_tog <= 1'b0;
            rise_bit <= 1'b1;
        end else begin
            rise_tog <= ~rise_tog;
            rise_bit <= i_sda;
        end
    end

    // ****************************************
    // Synchronisers
    // ****************************************
    logic tog_s1, tog_s2, tog_s3;
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic strap_s1, strap_s2;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            tog_s1 <= rise_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            strap_s1 <= i_strap;
            strap_s2 <= strap_s1;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_comb begin
        scl_rise = tog_s2 ^ tog_s3;
        scl_fall = scl_s3 & ~scl_s2;
        bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
        bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic legal_addr(input logic [7:0] a);
        return (a <= REG_LAST) || (a >= EE_BASE && a <= EE_LAST);
    endfunction

    // Pointer stops at the end of its memory instead of wrapping
    function automatic logic [7:0] ptr_inc(input logic [7:0] a);
        return (a == REG_LAST || a == EE_LAST) ? a : a + 8'h01;
    endfunction

    function automatic logic [7:0] cfg_default(input int idx);
        logic [7:0] a;
        a = CONV_BASE - 8'(CFG_N - idx);
        return (a >= CFG_DEF_LO && a <= CFG_DEF_HI) ? CFG_DEF_SET : CFG_RESET;
    endfunction

    // ****************************************
    // Storage and read decode
    // ****************************************
    logic [7:0] cfg [CFG_N];
    logic [7:0] ee [CFG_N];
    logic [7:0] ptr;
    logic [7:0] shreg;
    logic [7:0] rd_data;
    logic [3:0] conv_idx;

    always_comb begin
        conv_idx = 4'((ptr - CONV_BASE) >> 1);
        rd_data = READ_ZERO;
        if (ptr <= CFG_LAST) begin
            rd_data = cfg[5'(ptr)];
        end else if (ptr >= EE_BASE && ptr <= EE_LAST) begin
            rd_data = ee[5'(ptr - EE_BASE)];
        end else if (ptr >= CONV_BASE && ptr <= SUPPLY_CONVERSION_LOW) begin
            if (ptr[0]) begin
                rd_data = {6'h00, i_conv_result[3'(conv_idx)][1:0]};
            end else begin
                rd_data = i_conv_result[3'(conv_idx)][9:2];
            end
        end else if (ptr == PRIMARY_DETECTOR_FAULT_FLAGS) begin
            rd_data = i_fault_primary;
        end else if (ptr == SECONDARY_DETECTOR_FAULT_FLAGS) begin
            rd_data = i_fault_secondary;
        end else if (ptr == OUTPUT_EVENT_FAULT_FLAGS) begin
            rd_data = i_fault_output;
        end
    end

    // ****************************************
    // Byte decisions
    // ****************************************
    logic busy;
    logic addr_ok;
    logic cmd_ok;

    always_comb begin
        busy = o_reboot_busy | o_ee_busy;
        addr_ok = shreg[7:4] == ADDR_FIXED && !shreg[3] && shreg[2] == strap_s2;
        cmd_ok = !busy && (shreg == CMD_BLK_WR || shreg == CMD_BLK_RD ||
                 shreg == CMD_REBOOT || legal_addr(shreg));
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    sssp_state_t state;
    sssp_kind_t kind;
    logic [3:0] bitcnt;
    logic [7:0] txreg;
    logic read_dir;
    logic blk_wr;
    logic blk_rd;
    logic blk_cnt_due;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic reboot_go;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            kind <= BY_ADDR;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            read_dir <= 1'b0;
            blk_wr <= 1'b0;
            blk_rd <= 1'b0;
            blk_cnt_due <= 1'b0;
            ptr <= 8'h00;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            reboot_go <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            wr_en <= 1'b0;
            reboot_go <= 1'b0;
            if (bus_stop) begin
                // Pointer left alone: a cut frame must not move it
                state <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
                blk_wr <= 1'b0;
                blk_rd <= 1'b0;
                // Else a block write cut before its count swallows the next data byte
                blk_cnt_due <= 1'b0;
            end else if (bus_start) begin
                state <= ST_RX;
                kind <= BY_ADDR;
                bitcnt <= 4'h0;
                o_sda_oe_n <= 1'b1;
            end else if (scl_rise && state != ST_IDLE) begin
                shreg <= {shreg[6:0], rise_bit};
                bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
                unique case (state)
                    ST_IDLE: begin
                        o_sda_oe_n <= 1'b1;
                    end
                    ST_RX: begin
                        if (bitcnt == 4'h8) begin
                            state <= ST_ACK;
                            o_sda_oe_n <= 1'b0;
                            unique case (kind)
                                BY_ADDR: begin
                                    read_dir <= shreg[0];
                                    if (!addr_ok) begin
                                        state <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end
                                end
                                BY_CMD: begin
                                    if (!cmd_ok) begin
                                        state <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end else if (shreg == CMD_BLK_WR) begin
                                        blk_wr <= 1'b1;
                                        blk_cnt_due <= 1'b1;
                                    end else if (shreg == CMD_BLK_RD) begin
                                        blk_rd <= 1'b1;
                                    end else if (shreg == CMD_REBOOT) begin
                                        reboot_go <= 1'b1;
                                    end else begin
                                        ptr <= shreg;
                                    end
                                end
                                default: begin
                                    if (blk_cnt_due) begin
                                        blk_cnt_due <= 1'b0;
                                    end else begin
                                        wr_en <= 1'b1;
                                        wr_addr <= ptr;
                                        wr_data <= shreg;
                                        if (blk_wr) begin
                                            ptr <= ptr_inc(ptr);
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (bitcnt == 4'h9) begin
                            bitcnt <= 4'h0;
                            o_sda_oe_n <= 1'b1;
                            if (kind == BY_ADDR && read_dir) begin
                                state <= ST_TX;
                                if (blk_rd) begin
                                    blk_rd <= 1'b0;
                                    txreg <= BLK_RD_COUNT;
                                    o_sda_oe_n <= BLK_RD_COUNT[7];
                                end else begin
                                    txreg <= rd_data;
                                    o_sda_oe_n <= rd_data[7];
                                    ptr <= ptr_inc(ptr);
                                end
                            end else begin
                                state <= ST_RX;
                                kind <= (kind == BY_ADDR) ? BY_CMD : BY_DATA;
                            end
                        end
                    end
                    ST_TX: begin
                        if (bitcnt == 4'h8) begin
                            o_sda_oe_n <= 1'b1;
                        end else if (bitcnt == 4'h9) begin
                            if (!shreg[0]) begin
                                bitcnt <= 4'h0;
                                txreg <= rd_data;
                                o_sda_oe_n <= rd_data[7];
                                ptr <= ptr_inc(ptr);
                            end else begin
                                state <= ST_IDLE;
                                o_sda_oe_n <= 1'b1;
                            end
                        end else if (bitcnt != 4'h0) begin
                            o_sda_oe_n <= txreg[6];
                            txreg <= {txreg[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Volatile config and stored image
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < CFG_N; i++) begin
                cfg[i] <= cfg_default(i);
                ee[i] <= cfg_default(i);
            end
        end else if (reboot_go) begin
            for (int i = 0; i < CFG_N; i++) begin
                cfg[i] <= ee[i];
            end
        end else if (wr_en) begin
            if (wr_addr <= CFG_LAST) begin
                cfg[5'(wr_addr)] <= wr_data;
            end else if (wr_addr >= EE_BASE && wr_addr <= EE_LAST) begin
                ee[5'(wr_addr - EE_BASE)] <= wr_data;
            end
        end
    end

    // ****************************************
    // Busy timers
    // ****************************************
    logic [23:0] boot_cnt;
    logic [15:0] ee_cnt;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_cnt <= 24'h000000;
            o_reboot_busy <= 1'b0;
        end else if (reboot_go) begin
            boot_cnt <= 24'(P_BOOT_CYC);
            o_reboot_busy <= 1'b1;
        end else if (boot_cnt != 24'h000000) begin
            boot_cnt <= boot_cnt - 24'h000001;
            o_reboot_busy <= boot_cnt != 24'h000001;
        end
    end

    // EEPROM write time is not modelled from cell physics, only as a busy window
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ee_cnt <= 16'h0000;
            o_ee_busy <= 1'b0;
        end else if (wr_en && wr_addr >= EE_BASE && wr_addr <= EE_LAST) begin
            ee_cnt <= 16'(EE_WR_CYC);
            o_ee_busy <= 1'b1;
        end else if (ee_cnt != 16'h0000) begin
            ee_cnt <= ee_cnt - 16'h0001;
            o_ee_busy <= ee_cnt != 16'h0001;
        end
    end

    // Open drain: only the enable moves, the driven level is always low
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
        end
    end

endmodule

// >>> verification/sssp_core_assertions.sv
// Pin-level protocol checker for the serial slave port
module sssp_core_assertions
    import sssp_pkg::*;
#(
    parameter int P_BOOT_CYC = BOOT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_strap,
    input wire logic [7:0][9:0] i_conv_result,
    input wire logic [7:0] i_fault_primary,
    input wire logic [7:0] i_fault_secondary,
    input wire logic [7:0] i_fault_output,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic o_reboot_busy,
    input wire logic o_ee_busy
);
    // ****************************************
    // Busy window length counters
    // ****************************************
    logic [15:0] boot_cnt;
    logic [15:0] ee_cnt;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_cnt <= 16'h0000;
        end else begin
            boot_cnt <= o_reboot_busy ? boot_cnt + 16'h0001 : 16'h0000;
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ee_cnt <= 16'h0000;
        end else begin
            ee_cnt <= o_ee_busy ? ee_cnt + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ****************************************
    // Properties
    // ****************************************
    property p_drive_low;
        !o_sda_oe_n |-> !o_sda_out;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda driven high");
    // Changing data under a high clock would look like START or STOP
    property p_change_scl_low;
        $changed(o_sda_oe_n) |-> !i_scl;
    endproperty
    a_change_scl_low: assert property (p_change_scl_low) else $error("sda moved, scl high");
    property p_ack_holds;
        $rose(i_scl) && !o_sda_oe_n |-> !o_sda_oe_n [*8];
    endproperty
    a_ack_holds: assert property (p_ack_holds) else $error("ack dropped early");
    property p_boot_len;
        $fell(o_reboot_busy) |-> boot_cnt == 16'(P_BOOT_CYC);
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("reboot delay length wrong");
    property p_ee_len;
        $fell(o_ee_busy) |-> ee_cnt == 16'(EE_WR_CYC);
    endproperty
    a_ee_len: assert property (p_ee_len) else $error("store window length wrong");
    property p_stop_idle;
        i_scl && $rose(i_sda) |-> o_sda_oe_n [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
    property p_start_idle;
        i_scl && $fell(i_sda) |-> o_sda_oe_n [*8];
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("drive after start");
    property p_reset_idle;
        $rose(i_rstn) |-> o_sda_oe_n && !o_reboot_busy && !o_ee_busy;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    c_ack: cover property ($fell(o_sda_oe_n));
    c_boot: cover property ($rose(o_reboot_busy));
    c_ee: cover property ($rose(o_ee_busy));
endmodule

bind sssp_core sssp_core_assertions #(.P_BOOT_CYC(P_BOOT_CYC)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .i_strap(i_strap),
    .i_conv_result(i_conv_result), .i_fault_primary(i_fault_primary),
    .i_fault_secondary(i_fault_secondary), .i_fault_output(i_fault_output),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_reboot_busy(o_reboot_busy),
    .o_ee_busy(o_ee_busy)
);

// >>> verification/sssp_bus_master.sv
// Behavioural two-wire bus master driving the slave port
module sssp_bus_master (
    output logic o_scl,
    output logic o_sda_rel,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // About 356 kHz, 2808 ns per bit; hold of 300 ns keeps data edges clear of clock edges
    localparam time HALF = 1254;
    localparam time HOLD = 300;

    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end

    // Serves as repeated START as well; clock idles high between frames
    task automatic start_cond();
        o_sda_rel = 1'b1;
        #HALF;
        o_scl = 1'b1;
        #HALF;
        o_sda_rel = 1'b0;
        #HALF;
        o_scl = 1'b0;
        #HOLD;
    endtask

    task automatic stop_cond();
        o_sda_rel = 1'b0;
        #HALF;
        o_scl = 1'b1;
        #HALF;
        o_sda_rel = 1'b1;
        #HALF;
    endtask

    task automatic bit_xfer(input logic b, output logic s);
        o_sda_rel = b;
        #HALF;
        o_scl = 1'b1;
        #(HALF / 2);
        s = i_sda;
        #(HALF / 2);
        o_scl = 1'b0;
        #HOLD;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, ack);
    endtask

    task automatic rd_byte(output logic [7:0] v, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, v[i]);
        end
        bit_xfer(nack, s);
    endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the serial slave port
module tb
    import sssp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BOOT_SIM = 800;
    localparam logic [7:0] DEV_W = 8'hA0;
    localparam logic [7:0] DEV_R = 8'hA1;
    logic i_clk, i_rstn, i_strap, o_sda_out, o_sda_oe_n, o_reboot_busy, o_ee_busy;
    logic [7:0][9:0] i_conv_result;
    logic [7:0] i_fault_primary, i_fault_secondary, i_fault_output;
    logic scl, sda_rel;
    wire logic sda;
    int fail_count, tests_run;

    // Pull-up resolves the open-drain line
    assign sda = sda_rel & (o_sda_oe_n | o_sda_out);

    sssp_core #(.P_BOOT_CYC(BOOT_SIM)) uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .i_strap(i_strap),
        .i_conv_result(i_conv_result), .i_fault_primary(i_fault_primary),
        .i_fault_secondary(i_fault_secondary), .i_fault_output(i_fault_output),
        .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_reboot_busy(o_reboot_busy),
        .o_ee_busy(o_ee_busy)
    );
    sssp_bus_master m (.o_scl(scl), .o_sda_rel(sda_rel), .i_sda(sda));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wb(input logic [7:0] b, input logic nack);
        logic a;
        m.wr_byte(b, a);
        chk("ack", {7'h00, a}, {7'h00, nack});
    endtask
    task automatic sendp(input logic [7:0] p);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(p, 1'b0);
        m.stop_cond();
    endtask
    task automatic wr1(input logic [7:0] c, input logic [7:0] d);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(c, 1'b0);
        wb(d, 1'b0);
        m.stop_cond();
    endtask
    task automatic rdn(input logic [7:0] e[$]);
        logic [7:0] v;
        m.start_cond();
        wb(DEV_R, 1'b0);
        foreach (e[i]) begin
            m.rd_byte(v, i == e.size() - 1);
            chk("rd", v, e[i]);
        end
        m.stop_cond();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_default();
        chk("idle", {5'h00, o_sda_oe_n, o_reboot_busy, o_ee_busy}, 8'h04);
        sendp(8'h10);
        rdn('{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00});
    endtask
    task automatic t_addr();
        logic [7:0] ad [5] = '{8'hA8, 8'hA4, 8'hA2, 8'hA4, 8'hA0};
        logic [4:0] nk = 5'b11001;
        for (int i = 0; i < 5; i++) begin
            @(negedge i_clk) i_strap = (i > 2);
            repeat (4) @(negedge i_clk);
            m.start_cond();
            wb(ad[i], nk[4 - i]);
            m.stop_cond();
        end
        @(negedge i_clk) i_strap = 1'b0;
    endtask
    task automatic t_write();
        wr1(8'h01, 8'h5A);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(8'h03, 1'b0);
        wb(8'h11, 1'b0);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(8'h04, 1'b0);
        wb(8'h22, 1'b0);
        m.stop_cond();
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(8'h01, 1'b0);
        rdn('{8'h5A});
        sendp(8'h03);
        rdn('{8'h11, 8'h22});
    endtask
    task automatic t_regs();
        sendp(8'h25);
        rdn('{{6'h00, i_conv_result[6][1:0]}, i_conv_result[7][9:2],
              {6'h00, i_conv_result[7][1:0]}, i_fault_primary, i_fault_secondary,
              i_fault_output, 8'h00});
        sendp(8'h28);
        m.start_cond();
        wb(DEV_W, 1'b0);
        m.stop_cond();
        rdn('{i_fault_primary});
    endtask
    task automatic t_cmds();
        logic [7:0] bad [4] = '{8'h30, 8'h7F, 8'h98, 8'hC2};
        sendp(8'h02);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(CMD_BLK_WR, 1'b0);
        wb(8'h01, 1'b0);
        wb(8'h6C, 1'b0);
        m.stop_cond();
        sendp(8'h02);
        rdn('{8'h6C});
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(CMD_BLK_RD, 1'b0);
        rdn('{BLK_RD_COUNT});
        foreach (bad[i]) begin
            m.start_cond();
            wb(DEV_W, 1'b0);
            wb(bad[i], 1'b1);
            m.stop_cond();
        end
    endtask
    task automatic t_reboot();
        wr1(8'h81, 8'hAA);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(8'h01, 1'b1);
        m.stop_cond();
        for (int k = 0; k < 2000 && o_ee_busy !== 1'b0; k++) @(negedge i_clk);
        chk("ee_busy", {7'h00, o_ee_busy}, 8'h00);
        wr1(8'h01, 8'h33);
        sendp(CMD_REBOOT);
        chk("boot_busy", {7'h00, o_reboot_busy}, 8'h01);
        m.start_cond();
        wb(DEV_W, 1'b0);
        wb(8'h01, 1'b1);
        m.stop_cond();
        for (int k = 0; k < 2000 && o_reboot_busy !== 1'b0; k++) @(negedge i_clk);
        chk("boot_busy", {7'h00, o_reboot_busy}, 8'h00);
        sendp(8'h01);
        rdn('{8'hAA});
    endtask

    initial begin
        i_rstn = 1'b0;
        i_strap = 1'b0;
        fail_count = 0;
        tests_run = 0;
        i_conv_result = '0;
        i_conv_result[6] = 10'h3FE;
        i_conv_result[7] = 10'h2C7;
        i_fault_primary = 8'hA5;
        i_fault_secondary = 8'h3C;
        i_fault_output = 8'h07;
        repeat (4) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
        t_default();
        t_addr();
        t_write();
        t_regs();
        t_cmds();
        t_reboot();
        test_done();
    end

    // Whole run needs about 2.5 ms of bus traffic
    initial begin
        #6_000_000;
        fail_count++;
        test_done();
    end
endmodule
